// *** pkg/rlc_pkg.sv ***
/*
 * Constants and types of the remote/local control front end.
 * Assumes bus lines arrive as true-high levels behind the bus transceivers.
 */
package rlc_pkg;

    // ------------------------------------------------------------
    // Bus address
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_RESET = 5'h1c;
    localparam logic [4:0] ADDR_MAX   = 5'h1e;

    // ------------------------------------------------------------
    // Interface message codes
    // ------------------------------------------------------------
    localparam logic [7:0] MSG_GTL     = 8'h01;
    localparam logic [7:0] MSG_LLO     = 8'h11;
    localparam logic [7:0] MSG_UNL     = 8'h3f;
    localparam logic [7:0] MSG_UNT     = 8'h5f;
    localparam logic [2:0] LISTEN_BASE = 3'h1;
    localparam logic [2:0] TALK_BASE   = 3'h2;

    // ------------------------------------------------------------
    // Serial framing and control characters
    // ------------------------------------------------------------
    localparam int         UART_DATA_BITS = 8;
    localparam int         UART_STOP_BITS = 1;
    localparam logic [7:0] CHAR_CR        = 8'h0d;
    localparam logic [7:0] CHAR_LF        = 8'h0a;
    localparam logic [15:0] BAUD_DIV_MIN  = 16'h0004;

    // ------------------------------------------------------------
    // Widths and synchroniser depth
    // ------------------------------------------------------------
    localparam int SETTINGS_W     = 32;
    localparam int SYNC_STAGES    = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {RLC_LOCAL, RLC_REMOTE} rlc_mode_t;
    typedef enum logic {AH_IDLE, AH_ACCEPTED} rlc_ah_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rlc_rx_t;

endpackage : rlc_pkg

// *** hw/rlc_sync.sv ***
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes each bit is an independent slow level.
 */
`timescale 1ns/1ps
module rlc_sync
    import rlc_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta;

    initial begin
        if (W < 1) $error("rlc_sync: W must be at least 1");
    end

    // First stage is read only by the second
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : rlc_sync

// *** hw/rlc_uart_rx.sv ***
/*
 * Serial receiver, 8 data bits, no parity, 1 stop bit.
 * Assumes rx_in is already synchronised and baud_div_in is clocks per bit.
 */
`timescale 1ns/1ps
module rlc_uart_rx
    import rlc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    // Line and rate
    input  wire logic        rx_in,
    input  wire logic [15:0] baud_div_in,
    // Received byte
    output logic [7:0]       byte_out,
    output logic             valid_out,
    output logic             frame_err_out
);

    rlc_rx_t     state;
    logic [15:0] cnt;
    logic [2:0]  bit_idx;
    logic [15:0] div;

    // Too small a divisor cannot place the mid-bit sample
    assign div = (baud_div_in < BAUD_DIV_MIN) ? BAUD_DIV_MIN : baud_div_in;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state         <= RX_IDLE;
            cnt           <= 16'h0000;
            bit_idx       <= 3'h0;
            byte_out      <= 8'h00;
            valid_out     <= 1'b0;
            frame_err_out <= 1'b0;
        end else begin
            valid_out     <= 1'b0;
            frame_err_out <= 1'b0;
            unique case (state)
                RX_IDLE: begin
                    if (!rx_in) begin
                        state <= RX_START;
                        cnt   <= {1'b0, div[15:1]};
                    end
                end
                RX_START: begin
                    if (cnt != 16'h0000) begin
                        cnt <= cnt - 16'h0001;
                    end else if (rx_in) begin
                        state <= RX_IDLE;
                    end else begin
                        state   <= RX_DATA;
                        cnt     <= div - 16'h0001;
                        bit_idx <= 3'h0;
                    end
                end
                RX_DATA: begin
                    if (cnt != 16'h0000) begin
                        cnt <= cnt - 16'h0001;
                    end else begin
                        byte_out <= {rx_in, byte_out[7:1]};
                        cnt      <= div - 16'h0001;
                        bit_idx  <= bit_idx + 3'h1;
                        if (bit_idx == 3'h7) state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (cnt != 16'h0000) begin
                        cnt <= cnt - 16'h0001;
                    end else begin
                        state         <= RX_IDLE;
                        valid_out     <= rx_in;
                        frame_err_out <= !rx_in;
                    end
                end
            endcase
        end
    end

endmodule : rlc_uart_rx

// *** hw/rlc_remote_local.sv ***
/*
 * Remote/local state keeper and bus message sorter of an instrument.
 * Assumes true-high bus levels, a command processor on the same clock
 * that handles device messages, and a front panel that drives the key pin.
 */
`timescale 1ns/1ps

// Function
// - Power-on enters local state
// - Listen-addressed bus command enters remote
// - Serial CR or LF enters remote
// - Panel cannot change settings in remote
// - Remote held until key or bus release
// - Mode switch keeps all settings
// - Address resets to 28, accepts 0..30
// - Address writable from panel and bus command
// - LLO locks out the local key
// - REN false re-enables the local key
// - Show lockout; honour key only unlocked, or in serial remote
// - Key during busy returns remote afterwards
// - Serial is 8N1, rate and handshake selectable
// - Serial remote leaves only by local key
// - ATN bytes are interface messages
// - Non-ATN bytes are device messages
// - Universal always, addressed only when listener
// - Serial carries device messages only
// - Responses only after a query
// - Conflicting remote commands are ignored
module rlc_remote_local
    import rlc_pkg::*;
#(
    parameter int SET_W = SETTINGS_W
) (
    // Clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_n_in,
    // Parallel bus pins
    input  wire logic [7:0]       bus_dio_in,
    input  wire logic             bus_dav_in,
    input  wire logic             bus_atn_in,
    input  wire logic             bus_ren_in,
    output logic                  bus_rfd_out,
    output logic                  bus_dac_out,
    // Serial pins and serial_settings_menu
    input  wire logic             ser_rx_in,
    input  wire logic [15:0]      baud_div_in,
    input  wire logic             handshake_en_in,
    output logic                  ser_cts_out,
    // Front panel
    input  wire logic             local_key_in,
    input  wire logic             panel_set_wr_in,
    input  wire logic [SET_W-1:0] panel_set_in,
    input  wire logic             bus_address_menu_wr_in,
    input  wire logic [4:0]       bus_address_menu_in,
    // Command processor
    input  wire logic             cmd_busy_in,
    input  wire logic             cmd_set_wr_in,
    input  wire logic [SET_W-1:0] cmd_set_in,
    input  wire logic             cmd_conflict_in,
    input  wire logic             set_bus_address_command_in,
    input  wire logic [4:0]       cmd_addr_in,
    input  wire logic             cmd_query_in,
    input  wire logic             resp_valid_in,
    input  wire logic [7:0]       resp_byte_in,
    input  wire logic             resp_last_in,
    // Device messages towards the command processor
    output logic [7:0]            dev_byte_out,
    output logic                  dev_valid_out,
    output logic                  dev_from_serial_out,
    output logic                  frame_err_out,
    // Responses towards the controller
    output logic [7:0]            resp_byte_out,
    output logic                  resp_valid_out,
    // State indications
    output logic                  remote_out,
    output logic                  via_serial_out,
    output logic                  lockout_out,
    output logic                  listener_out,
    output logic                  talker_out,
    output logic [4:0]            bus_addr_out,
    output logic [SET_W-1:0]      settings_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    rlc_mode_t  mode;
    rlc_ah_t    ah_state;
    logic [7:0] s_dio;
    logic       s_dav;
    logic       s_atn;
    logic       s_ren;
    logic       s_key;
    logic       s_rx;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       rx_ferr;
    logic       key_q;
    logic       busy_q;
    logic       rebound;
    logic       query_pending;
    logic       take;
    logic       if_msg;
    logic       dev_msg;
    logic       llo_hit;
    logic       gtl_hit;
    logic       my_listen;
    logic       my_talk;
    logic       remote_bus;
    logic       serial_term;
    logic       key_rise;
    logic       key_ok;
    logic       busy_done;
    logic       panel_ok;
    logic       cmd_ok;

    initial begin
        if (SET_W < 1) $error("rlc_remote_local: SET_W must be at least 1");
    end

    // ------------------------------------------------------------
    // Pin synchronisers and serial receiver
    // ------------------------------------------------------------
    rlc_sync #(.W(13)) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   ({bus_dio_in, bus_dav_in, bus_atn_in, bus_ren_in, local_key_in, ser_rx_in}),
        .sync_out   ({s_dio, s_dav, s_atn, s_ren, s_key, s_rx})
    );

    // 8N1 framing is fixed; only the rate comes from the menu
    rlc_uart_rx u_rx (
        .sys_clk_in    (sys_clk_in),
        .rst_n_in      (rst_n_in),
        .rx_in         (s_rx),
        .baud_div_in   (baud_div_in),
        .byte_out      (rx_byte),
        .valid_out     (rx_valid),
        .frame_err_out (rx_ferr)
    );

    // Hold-off when busy only if the controller honours the handshake
    assign ser_cts_out = !handshake_en_in || !cmd_busy_in;

    // ------------------------------------------------------------
    // Acceptor handshake
    // ------------------------------------------------------------
    // A serial byte has the output slot first; the bus byte waits a cycle
    assign take = (ah_state == AH_IDLE) && s_dav && !rx_valid;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ah_state <= AH_IDLE;
        end else begin
            unique case (ah_state)
                AH_IDLE:     if (take) ah_state <= AH_ACCEPTED;
                AH_ACCEPTED: if (!s_dav) ah_state <= AH_IDLE;
            endcase
        end
    end

    assign bus_rfd_out = (ah_state == AH_IDLE);
    assign bus_dac_out = (ah_state == AH_ACCEPTED);

    // ------------------------------------------------------------
    // Message sorting
    // ------------------------------------------------------------
    assign if_msg    = take && s_atn;
    assign dev_msg   = take && !s_atn && listener_out;
    assign my_listen = if_msg && (s_dio == {LISTEN_BASE, bus_addr_out});
    assign my_talk   = if_msg && (s_dio == {TALK_BASE, bus_addr_out});
    assign llo_hit   = if_msg && (s_dio == MSG_LLO);
    assign gtl_hit   = if_msg && (s_dio == MSG_GTL) && listener_out;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            listener_out <= 1'b0;
            talker_out   <= 1'b0;
        end else if (if_msg) begin
            if (my_listen) listener_out <= 1'b1;
            else if (s_dio == MSG_UNL) listener_out <= 1'b0;
            if (my_talk) talker_out <= 1'b1;
            else if ((s_dio == MSG_UNT) || (s_dio[7:5] == TALK_BASE)) talker_out <= 1'b0;
        end
    end

    // Serial bytes are always device messages
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dev_byte_out        <= 8'h00;
            dev_valid_out       <= 1'b0;
            dev_from_serial_out <= 1'b0;
            frame_err_out       <= 1'b0;
        end else begin
            dev_valid_out <= rx_valid || dev_msg;
            frame_err_out <= rx_ferr;
            if (rx_valid) begin
                dev_byte_out        <= rx_byte;
                dev_from_serial_out <= 1'b1;
            end else if (dev_msg) begin
                dev_byte_out        <= s_dio;
                dev_from_serial_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Remote and local state
    // ------------------------------------------------------------
    assign remote_bus  = my_listen && s_ren;
    assign serial_term = rx_valid && ((rx_byte == CHAR_CR) || (rx_byte == CHAR_LF));
    assign key_rise    = s_key && !key_q;
    // Lockout only guards a bus-controlled session
    assign key_ok      = key_rise && (!lockout_out || via_serial_out);
    assign busy_done   = busy_q && !cmd_busy_in;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            key_q  <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            key_q  <= s_key;
            busy_q <= cmd_busy_in;
        end
    end

    // Entries come last so that a new remote request wins
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode           <= RLC_LOCAL;
            via_serial_out <= 1'b0;
        end else begin
            if (mode == RLC_REMOTE) begin
                if (!via_serial_out && (!s_ren || gtl_hit)) mode <= RLC_LOCAL;
                if (key_ok) mode <= RLC_LOCAL;
            end
            if (rebound && busy_done) mode <= RLC_REMOTE;
            if (remote_bus) begin
                mode           <= RLC_REMOTE;
                via_serial_out <= 1'b0;
            end
            if (serial_term) begin
                mode           <= RLC_REMOTE;
                via_serial_out <= 1'b1;
            end
        end
    end

    assign remote_out = (mode == RLC_REMOTE);

    // Remember a key press that arrived while a command was still running
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rebound <= 1'b0;
        end else if (remote_out && key_ok && cmd_busy_in) begin
            rebound <= 1'b1;
        end else if (busy_done || remote_bus || serial_term) begin
            rebound <= 1'b0;
        end
    end

    // Set wins over the clear by REN
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lockout_out <= 1'b0;
        end else if (llo_hit) begin
            lockout_out <= 1'b1;
        end else if (!s_ren) begin
            lockout_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Settings and bus address
    // ------------------------------------------------------------
    assign panel_ok = !remote_out;
    assign cmd_ok   = remote_out && !cmd_conflict_in;

    // Mode changes never touch this register
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            settings_out <= '0;
        end else if (cmd_set_wr_in && cmd_ok) begin
            settings_out <= cmd_set_in;
        end else if (panel_set_wr_in && panel_ok) begin
            settings_out <= panel_set_in;
        end
    end

    // The controller must follow a changed address itself
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_addr_out <= ADDR_RESET;
        end else if (set_bus_address_command_in && cmd_ok && (cmd_addr_in <= ADDR_MAX)) begin
            bus_addr_out <= cmd_addr_in;
        end else if (bus_address_menu_wr_in && panel_ok
                     && (bus_address_menu_in <= ADDR_MAX)) begin
            bus_addr_out <= bus_address_menu_in;
        end
    end

    // ------------------------------------------------------------
    // Responses
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            query_pending <= 1'b0;
        end else if (cmd_query_in) begin
            query_pending <= 1'b1;
        end else if (resp_valid_in && resp_last_in) begin
            query_pending <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            resp_byte_out  <= 8'h00;
            resp_valid_out <= 1'b0;
        end else begin
            resp_valid_out <= resp_valid_in && query_pending;
            if (resp_valid_in && query_pending) resp_byte_out <= resp_byte_in;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_key_in_busy;
        remote_out && key_ok && cmd_busy_in && !remote_bus && !serial_term;
    endsequence

    sequence s_busy_ends;
        !cmd_busy_in && !key_ok;
    endsequence

    a_serial_term_remote: assert property (serial_term |=> remote_out && via_serial_out)
        else $error("CR or LF on serial did not enter remote");
    a_listen_remote: assert property (remote_bus && !serial_term |=> remote_out && !via_serial_out)
        else $error("Listen address with REN did not enter bus remote");
    a_llo_locks: assert property (llo_hit |=> lockout_out)
        else $error("LLO did not lock the local key");
    a_ren_unlocks: assert property (!s_ren && !llo_hit |=> !lockout_out)
        else $error("REN false left the key locked");
    a_locked_key: assert property (remote_out && lockout_out && !via_serial_out && s_ren
                                   && !gtl_hit |=> remote_out)
        else $error("Locked local key left remote");
    a_addr_range: assert property (bus_addr_out <= ADDR_MAX)
        else $error("Bus address outside 0 to 30");
    a_panel_blocked: assert property (remote_out && !cmd_set_wr_in |=> $stable(settings_out))
        else $error("Panel changed settings in remote");
    a_mode_keeps: assert property ($changed(mode) && !$past(cmd_set_wr_in)
                                   && !$past(panel_set_wr_in) |-> $stable(settings_out))
        else $error("Mode change altered settings");
    a_busy_rebound: assert property (s_key_in_busy ##1 (s_busy_ends [*2])
                                     |=> remote_out)
        else $error("Key during busy did not return to remote");
    a_serial_stays: assert property (remote_out && via_serial_out && !key_rise
                                     |=> remote_out)
        else $error("Serial remote left without the local key");
    a_resp_query: assert property (resp_valid_out |-> $past(query_pending))
        else $error("Response sent without a query");
    a_conflict_ignored: assert property (cmd_set_wr_in && cmd_conflict_in && !panel_set_wr_in
                                         |=> $stable(settings_out))
        else $error("Conflicting command changed settings");
    a_dev_msg: assert property (dev_msg && !rx_valid |=> dev_valid_out && !dev_from_serial_out
                                && dev_byte_out == $past(s_dio))
        else $error("Device message from bus not passed on");
    a_local_at_start: assert property ($rose(rst_n_in) |-> !remote_out)
        else $error("Not local after reset");

endmodule : rlc_remote_local

// *** bench/rlc_ctrl_model.sv ***
/* Controller model driving the bus and serial pins of the front end.
   Assumes one shared clock and 8 clocks per serial bit. */
`timescale 1ns/1ps
module rlc_ctrl_model (
    input  wire logic       clk_in,
    input  wire logic       dac_in,
    output logic [7:0]      dio_out  = 8'h00,
    output logic            dav_out  = 1'h0,
    output logic            atn_out  = 1'h0,
    output logic            rx_out   = 1'h1,
    output logic            hang_out = 1'h0
);
    task automatic wait_dac(input logic v);
        int n;
        n = 0;
        while (dac_in !== v && n < 40) begin
            @(posedge clk_in);
            #5;
            n++;
        end
        if (dac_in !== v) hang_out = 1'h1;
    endtask : wait_dac
    // Held until accepted; stale data is scrambled so it cannot pass as valid
    task automatic send_bus(input logic atn, input logic [7:0] b);
        @(posedge clk_in);
        #5;
        dio_out = b;
        atn_out = atn;
        dav_out = 1'h1;
        wait_dac(1'h1);
        dav_out = 1'h0;
        atn_out = 1'h0;
        dio_out = ~b;
        wait_dac(1'h0);
    endtask : send_bus
    // Start, 8 data LSB first, no parity, one stop
    task automatic send_ser(input logic [7:0] b);
        logic [9:0] f;
        f = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_in);
            #5;
            rx_out = f[i];
            repeat (7) @(posedge clk_in);
        end
    endtask : send_ser
endmodule : rlc_ctrl_model

// *** bench/test_remote_local_control.sv ***
/* Bench of the remote/local front end.
   Assumes the controller model owns the bus and serial pins. */
`timescale 1ns/1ps
module test_remote_local_control;
    logic        sys_clk_in = 0, rst_n_in = 0, bus_ren_in = 0, local_key_in = 0;
    logic        panel_set_wr_in = 0, bus_address_menu_wr_in = 0, cmd_set_wr_in = 0;
    logic        handshake_en_in = 0, cmd_busy_in = 0, cmd_conflict_in = 0;
    logic        set_bus_address_command_in = 0, cmd_query_in = 0;
    logic        resp_valid_in = 0, resp_last_in = 0;
    logic [4:0]  bus_address_menu_in = 0, cmd_addr_in = 0, bus_addr_out;
    logic [7:0]  resp_byte_in = 0, dev_byte_out, resp_byte_out;
    logic [15:0] baud_div_in = 16'h0008;
    logic [31:0] panel_set_in = 0, cmd_set_in = 0, settings_out;
    wire  logic [7:0] bus_dio_in;
    wire  logic  bus_dav_in, bus_atn_in, ser_rx_in, hang;
    logic        bus_rfd_out, bus_dac_out, ser_cts_out, dev_valid_out, frame_err_out;
    logic        dev_from_serial_out, resp_valid_out, remote_out, via_serial_out;
    logic        lockout_out, listener_out, talker_out;
    int          error_cnt = 0, n_tests = 0;
    rlc_remote_local dut (.*);
    rlc_ctrl_model ctl (.clk_in(sys_clk_in), .dac_in(bus_dac_out), .dio_out(bus_dio_in),
        .dav_out(bus_dav_in), .atn_out(bus_atn_in), .rx_out(ser_rx_in), .hang_out(hang));
    always #25 sys_clk_in = ~sys_clk_in;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #5;
    endtask : tick
    // Key is edge detected behind two sync flops, so hold it a few cycles
    task automatic key_press;
        local_key_in = 1;
        tick(4);
        local_key_in = 0;
        tick(4);
    endtask : key_press
    task automatic wr_addr(input logic [4:0] a);
        bus_address_menu_in = a;
        bus_address_menu_wr_in = 1;
        tick(1);
        bus_address_menu_wr_in = 0;
        tick(1);
    endtask : wr_addr
    task automatic t_addr;
        chk(remote_out, 1'h0);
        chk(bus_addr_out, 32'h1c);
        wr_addr(5'h1f);
        chk(bus_addr_out, 32'h1c);
        wr_addr(5'h1e);
        chk(bus_addr_out, 32'h1e);
        wr_addr(5'h1c);
    endtask : t_addr
    task automatic t_bus;
        bus_ren_in = 1;
        tick(3);
        ctl.send_bus(1'h1, 8'h3c);
        tick(2);
        chk(remote_out, 1'h1);
        chk(listener_out, 1'h1);
        cmd_set_in = 32'h2222;
        cmd_set_wr_in = 1;
        tick(1);
        cmd_set_wr_in = 0;
        panel_set_in = 32'h1111;
        panel_set_wr_in = 1;
        tick(1);
        panel_set_wr_in = 0;
        tick(1);
        chk(settings_out, 32'h2222);
    endtask : t_bus
    task automatic t_cmd;
        cmd_conflict_in = 1;
        cmd_set_in = 32'h3333;
        cmd_set_wr_in = 1;
        tick(1);
        cmd_set_wr_in = 0;
        cmd_conflict_in = 0;
        cmd_addr_in = 5'h14;
        set_bus_address_command_in = 1;
        tick(1);
        set_bus_address_command_in = 0;
        tick(1);
        chk(settings_out, 32'h2222);
        chk(bus_addr_out, 32'h14);
        ctl.send_bus(1'h1, 8'h3f);
        ctl.send_bus(1'h1, 8'h3c);
        chk(listener_out, 1'h0);
        ctl.send_bus(1'h1, 8'h34);
        ctl.send_bus(1'h1, 8'h54);
        chk(listener_out, 1'h1);
        chk(talker_out, 1'h1);
        ctl.send_bus(1'h1, 8'h01);
        chk(remote_out, 1'h0);
        ctl.send_bus(1'h0, 8'h41);
        chk(dev_byte_out, 32'h41);
        chk(dev_from_serial_out, 1'h0);
        chk(bus_rfd_out, 1'h1);
        ctl.send_bus(1'h1, 8'h34);
        chk(remote_out, 1'h1);
    endtask : t_cmd
    task automatic t_lock;
        ctl.send_bus(1'h1, 8'h11);
        tick(2);
        chk(lockout_out, 1'h1);
        key_press();
        chk(remote_out, 1'h1);
        bus_ren_in = 0;
        tick(4);
        chk(lockout_out, 1'h0);
        chk(remote_out, 1'h0);
        chk(settings_out, 32'h2222);
    endtask : t_lock
    task automatic t_serial;
        ctl.send_ser(8'h0d);
        tick(12);
        chk(remote_out, 1'h1);
        chk(via_serial_out, 1'h1);
        chk(dev_byte_out, 32'h0d);
        chk(dev_from_serial_out, 1'h1);
        handshake_en_in = 1;
        cmd_busy_in = 1;
        local_key_in = 1;
        tick(3);
        chk(remote_out, 1'h0);
        chk(ser_cts_out, 1'h0);
        cmd_busy_in = 0;
        tick(3);
        local_key_in = 0;
        tick(3);
        chk(remote_out, 1'h1);
        chk(ser_cts_out, 1'h1);
        key_press();
        chk(remote_out, 1'h0);
        ctl.send_ser(8'h0a);
        tick(12);
        chk(remote_out, 1'h1);
    endtask : t_serial
    task automatic t_query;
        resp_byte_in = 8'h5a;
        resp_valid_in = 1;
        resp_last_in = 1;
        tick(1);
        resp_valid_in = 0;
        chk(resp_valid_out, 1'h0);
        cmd_query_in = 1;
        tick(1);
        cmd_query_in = 0;
        resp_valid_in = 1;
        tick(1);
        resp_valid_in = 0;
        chk(resp_valid_out, 1'h1);
        chk(resp_byte_out, 32'h5a);
    endtask : t_query
    task automatic tally_and_finish;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        tick(10);
        rst_n_in = 1;
        tick(2);
        t_addr();
        t_bus();
        t_cmd();
        t_lock();
        t_serial();
        t_query();
        chk(hang, 1'h0);
        tally_and_finish();
    end
endmodule : test_remote_local_control
